// ==== verilog/dp_pkg.sv ====
// Shared constants and types of the debug port control registers
package dp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] DP_OFS_TURN = 4'h2; // Turnaround idle count
  localparam logic [3:0] DP_OFS_PORT_CONTROL_B = 4'h3; // Port control B
  localparam logic [3:0] DP_OFS_KEY = 4'h7; // Access key status
  localparam logic [3:0] DP_OFS_SYSTEM_RESET_REQUEST = 4'h8; // System reset request
  localparam logic [3:0] DP_OFS_CLKSEL = 4'h9; // Port clock select
  localparam logic [3:0] DP_OFS_SYSCTL = 4'ha; // System control
  localparam logic [3:0] DP_OFS_SYSSTAT = 4'hb; // System status
  localparam logic [3:0] DP_OFS_CRC = 4'hc; // Memory scan status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DP_BIT_NACK_SUP = 4; // Control B: negative ack suppress
  localparam int DP_BIT_CONT_OFF = 3; // Control B: contention check off
  localparam int DP_BIT_SHUTDOWN = 2; // Control B: port shutdown
  localparam int DP_BIT_KEY_UROW = 5; // Key status: user row key
  localparam int DP_BIT_KEY_PROG = 4; // Key status: memory program key
  localparam int DP_BIT_KEY_ERASE = 3; // Key status: full erase key
  localparam int DP_BIT_ROW_DONE = 1; // System control: user row done
  localparam int DP_BIT_CLK_REQ = 0; // System control: clock request
  localparam int DP_BIT_IN_RESET = 5; // Status: system in reset
  localparam int DP_BIT_ASLEEP = 4; // Status: system asleep
  localparam int DP_BIT_PROG_RDY = 3; // Status: programming ready
  localparam int DP_BIT_ROW_RDY = 2; // Status: user row ready
  localparam int DP_BIT_LOCKED = 0; // Status: device locked

  // ----------------------------------------------------------------
  // Values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DP_RST_SIGNATURE = 8'h59; // Reset request signature
  localparam logic [2:0] DP_TURN_RESET = 3'h0; // 128 idle bits
  localparam logic [2:0] DP_TURN_OFF = 3'h7; // No idle bits
  localparam logic [7:0] DP_TURN_MAX = 8'h80; // Idle bits for code 0
  localparam logic [1:0] DP_CLK_RESERVED = 2'h0; // Reserved select code
  localparam logic [1:0] DP_CLK_FAST = 2'h1; // 16 MHz
  localparam logic [1:0] DP_CLK_MID = 2'h2; // 8 MHz
  localparam logic [1:0] DP_CLK_SLOW = 2'h3; // 4 MHz, the reset value
  localparam logic [2:0] DP_CRC_OFF = 3'h0; // Not enabled
  localparam logic [2:0] DP_CRC_BUSY = 3'h1; // Enabled, busy
  localparam logic [2:0] DP_CRC_GOOD = 3'h2; // Done, good signature
  localparam logic [2:0] DP_CRC_FAIL = 3'h4; // Done, failed signature

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DP_CLK_MHZ = 125; // System clock rate
  localparam int DP_FAST_MHZ = 16; // Fast port clock
  localparam int DP_MID_MHZ = 8; // Middle port clock
  localparam int DP_SLOW_MHZ = 4; // Slow port clock
  // Divider counts, rounded down so the port never runs slow
  localparam int DP_DIV_FAST = DP_CLK_MHZ / DP_FAST_MHZ;
  localparam int DP_DIV_MID = DP_CLK_MHZ / DP_MID_MHZ;
  localparam int DP_DIV_SLOW = DP_CLK_MHZ / DP_SLOW_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // System domain status, arriving from outside the clock domain
  typedef struct packed {
    logic reset_active;
    logic asleep;
    logic prog_ready;
    logic row_ready;
    logic locked;
    logic prog_done;
    logic erase_done;
    logic [2:0] crc;
  } dp_sys_type;

  // Settings handed to the physical layer
  typedef struct packed {
    logic [2:0] turnaround_idle_count;
    logic negative_ack_suppress;
    logic contention_check_off;
    logic [1:0] port_clock_select;
  } dp_phy_cfg_type;

  localparam int DP_SYS_W = 10; // Width of dp_sys_type
  localparam logic [DP_SYS_W-1:0] DP_SYS_RESET = 10'h020; // Locked at reset

endpackage : dp_pkg

// ==== verilog/dp_rate_gen.sv ====
// Port bit-rate enable generator
`timescale 1ns/10ps
module dp_rate_gen
  import dp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i, // Restart the divider
  input wire logic [1:0] sel_i, // Port clock select
  output logic bit_en_o // One-cycle pulse per port clock
);

  logic [5:0] cnt_r; // Cycles left in this period
  logic [5:0] lim; // Reload value for the selection

  // Divider length; the reserved code never gets stored upstream
  always_comb begin
    case (sel_i)
      DP_CLK_FAST: lim = 6'(DP_DIV_FAST - 1);
      DP_CLK_MID: lim = 6'(DP_DIV_MID - 1);
      default: lim = 6'(DP_DIV_SLOW - 1);
    endcase
  end

  // Down counter, pulse on zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 6'h00;
      bit_en_o <= 1'b0;
    end else if (clear_i) begin
      cnt_r <= 6'h00;
      bit_en_o <= 1'b0;
    end else if (cnt_r == 6'h00) begin
      cnt_r <= lim;
      bit_en_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 6'h01;
      bit_en_o <= 1'b0;
    end
  end

endmodule : dp_rate_gen

// ==== verilog/dp_guard.sv ====
// Receive-to-transmit turnaround idle timer
`timescale 1ns/10ps
module dp_guard
  import dp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i, // Abort any running guard
  input wire logic start_i, // Port turns from receive to transmit
  input wire logic [2:0] code_i, // Turnaround idle count code
  input wire logic bit_en_i, // One pulse per bit time
  output logic busy_o // High while idle bits are inserted
);

  logic [7:0] cnt_r; // Idle bits still to insert

  // Load 128 halved per code step; code 7 loads nothing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
    end else if (clear_i) begin
      cnt_r <= 8'h00;
    end else if (start_i) begin
      cnt_r <= (code_i == DP_TURN_OFF) ? 8'h00 : (DP_TURN_MAX >> code_i);
    end else if (bit_en_i && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  assign busy_o = (cnt_r != 8'h00);

endmodule : dp_guard

// ==== verilog/dp_ctrl_regs.sv ====
// Control and status registers of the single-pin debug port
`timescale 1ns/10ps
module dp_ctrl_regs
  import dp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register access from the instruction decoder
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Port life cycle and keys from the instruction decoder
  input wire logic port_enable_i,
  input wire logic key_row_i,
  input wire logic key_prog_i,
  input wire logic key_erase_i,
  // Physical layer events
  input wire logic turn_i,
  input wire logic access_busy_i,
  input wire logic contention_i,
  // System domain status, asynchronous
  input wire dp_sys_type sys_i,
  // Outputs
  output dp_phy_cfg_type phy_cfg_o,
  output logic phy_enable_o,
  output logic port_logic_reset_o,
  output logic bit_en_o,
  output logic guard_busy_o,
  output logic nack_send_o,
  output logic contention_error_o,
  output logic system_reset_request_o,
  output logic system_clock_request_o,
  output logic user_row_done_o,
  output logic user_row_key_active_o,
  output logic memory_program_key_o,
  output logic full_erase_key_o
);

  // ----------------------------------------------------------------
  // Synchronisers for the system domain
  // ----------------------------------------------------------------
  logic [DP_SYS_W-1:0] sys_meta_r; // First stage, read by second only
  logic [DP_SYS_W-1:0] sys_sync_r; // Second stage, safe to use
  logic [DP_SYS_W-1:0] sys_prev_r; // Delayed copy for edges
  dp_sys_type sys_s; // Synchronised view
  dp_sys_type sys_p; // Previous synchronised view

  genvar gi;
  generate
    for (gi = 0; gi < DP_SYS_W; gi++) begin : g_sync
      // Three flops per bit, two to synchronise and one for edges; the crc field may be caught mid-change
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sys_meta_r[gi] <= DP_SYS_RESET[gi];
          sys_sync_r[gi] <= DP_SYS_RESET[gi];
          sys_prev_r[gi] <= DP_SYS_RESET[gi];
        end else begin
          sys_meta_r[gi] <= sys_i[gi];
          sys_sync_r[gi] <= sys_meta_r[gi];
          sys_prev_r[gi] <= sys_sync_r[gi];
        end
      end
    end
  endgenerate

  assign sys_s = sys_sync_r;
  assign sys_p = sys_prev_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_turn, wr_port_control_b, wr_key, wr_rst, wr_clk, wr_sysctl;
  logic rd_stat; // Status read, clears the sticky reset bit
  logic shutdown; // Port shutdown written this cycle

  assign wr_turn = reg_wr_i && reg_addr_i == DP_OFS_TURN;
  assign wr_port_control_b = reg_wr_i && reg_addr_i == DP_OFS_PORT_CONTROL_B;
  assign wr_key = reg_wr_i && reg_addr_i == DP_OFS_KEY;
  assign wr_rst = reg_wr_i && reg_addr_i == DP_OFS_SYSTEM_RESET_REQUEST;
  assign wr_clk = reg_wr_i && reg_addr_i == DP_OFS_CLKSEL;
  assign wr_sysctl = reg_wr_i && reg_addr_i == DP_OFS_SYSCTL;
  assign rd_stat = reg_rd_i && reg_addr_i == DP_OFS_SYSSTAT;
  assign shutdown = wr_port_control_b && reg_wdata_i[DP_BIT_SHUTDOWN];

  // ----------------------------------------------------------------
  // Physical layer settings
  // ----------------------------------------------------------------
  logic [2:0] turn_code_r; // Turnaround idle count code
  logic nack_sup_r; // Negative ack suppress
  logic cont_off_r; // Contention check off
  logic [1:0] clk_sel_r; // Port clock select

  // Turnaround code; shutdown restores the 128-bit default
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      turn_code_r <= DP_TURN_RESET;
    end else if (shutdown) begin
      turn_code_r <= DP_TURN_RESET;
    end else if (wr_turn) begin
      turn_code_r <= reg_wdata_i[2:0];
    end
  end

  // Control B flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nack_sup_r <= 1'b0;
      cont_off_r <= 1'b0;
    end else if (shutdown) begin
      nack_sup_r <= 1'b0;
      cont_off_r <= 1'b0;
    end else if (wr_port_control_b) begin
      nack_sup_r <= reg_wdata_i[DP_BIT_NACK_SUP];
      cont_off_r <= reg_wdata_i[DP_BIT_CONT_OFF];
    end
  end

  // Clock select; the reserved code is ignored so the divider stays sane.
  // Software must pick the fast codes only with the brown-out level high.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sel_r <= DP_CLK_SLOW;
    end else if (shutdown || port_enable_i) begin
      clk_sel_r <= DP_CLK_SLOW;
    end else if (wr_clk && reg_wdata_i[1:0] != DP_CLK_RESERVED) begin
      clk_sel_r <= reg_wdata_i[1:0];
    end
  end

  assign phy_cfg_o.turnaround_idle_count = turn_code_r;
  assign phy_cfg_o.negative_ack_suppress = nack_sup_r;
  assign phy_cfg_o.contention_check_off = cont_off_r;
  assign phy_cfg_o.port_clock_select = clk_sel_r;

  // ----------------------------------------------------------------
  // Port life cycle
  // ----------------------------------------------------------------
  // Enable and shutdown; the port logic reset is a one-cycle pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_enable_o <= 1'b0;
      port_logic_reset_o <= 1'b0;
    end else begin
      port_logic_reset_o <= shutdown;
      if (shutdown) begin
        phy_enable_o <= 1'b0;
      end else if (port_enable_i) begin
        phy_enable_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit timing and guard
  // ----------------------------------------------------------------
  dp_rate_gen u_rate (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(port_logic_reset_o),
    .sel_i(clk_sel_r),
    .bit_en_o(bit_en_o)
  );

  dp_guard u_guard (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(port_logic_reset_o),
    .start_i(turn_i && phy_enable_o),
    .code_i(turn_code_r),
    .bit_en_i(bit_en_o),
    .busy_o(guard_busy_o)
  );

  // ----------------------------------------------------------------
  // Negative ack and contention
  // ----------------------------------------------------------------
  // Reset entering mid-transfer triggers a negative ack unless suppressed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nack_send_o <= 1'b0;
      contention_error_o <= 1'b0;
    end else begin
      nack_send_o <= sys_s.reset_active && !sys_p.reset_active
                     && access_busy_i && !nack_sup_r;
      contention_error_o <= contention_i && !cont_off_r;
    end
  end

  // ----------------------------------------------------------------
  // Access keys
  // ----------------------------------------------------------------
  logic prog_done_ev; // Programming sequence finished
  logic erase_done_ev; // Full erase finished

  assign prog_done_ev = sys_s.prog_done && !sys_p.prog_done;
  assign erase_done_ev = sys_s.erase_done && !sys_p.erase_done;

  // Keys; a new acceptance wins over a completion in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      user_row_key_active_o <= 1'b0;
      memory_program_key_o <= 1'b0;
      full_erase_key_o <= 1'b0;
    end else if (shutdown) begin
      user_row_key_active_o <= 1'b0;
      memory_program_key_o <= 1'b0;
      full_erase_key_o <= 1'b0;
    end else begin
      if (key_row_i) begin
        user_row_key_active_o <= 1'b1;
      end else if (wr_key && !reg_wdata_i[DP_BIT_KEY_UROW]) begin
        user_row_key_active_o <= 1'b0;
      end
      if (key_prog_i) begin
        memory_program_key_o <= 1'b1;
      end else if (prog_done_ev) begin
        memory_program_key_o <= 1'b0;
      end
      if (key_erase_i) begin
        full_erase_key_o <= 1'b1;
      end else if (erase_done_ev) begin
        full_erase_key_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // System reset request
  // ----------------------------------------------------------------
  // Held until the next write to it or a shutdown; this flop never resets the port itself
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_reset_request_o <= 1'b0;
    end else if (shutdown) begin
      system_reset_request_o <= 1'b0;
    end else if (wr_rst) begin
      system_reset_request_o <= (reg_wdata_i == DP_RST_SIGNATURE);
    end
  end

  // ----------------------------------------------------------------
  // System control
  // ----------------------------------------------------------------
  // Clock request: set on enable, written by software, dropped on shutdown
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_clock_request_o <= 1'b0;
    end else if (shutdown) begin
      system_clock_request_o <= 1'b0;
    end else if (port_enable_i) begin
      system_clock_request_o <= 1'b1;
    end else if (wr_sysctl) begin
      system_clock_request_o <= reg_wdata_i[DP_BIT_CLK_REQ];
    end
  end

  // User row done pulse, only with the user row key held.
  // Writing early cannot be caught here; the processor moves on without data.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      user_row_done_o <= 1'b0;
    end else begin
      user_row_done_o <= wr_sysctl && reg_wdata_i[DP_BIT_ROW_DONE]
                         && user_row_key_active_o;
    end
  end

  // ----------------------------------------------------------------
  // System status
  // ----------------------------------------------------------------
  logic in_reset_r; // Sticky system reset seen
  logic rst_now; // System is in reset right now

  assign rst_now = sys_s.reset_active || system_reset_request_o;

  // Sticky bit; an ongoing reset wins over the clear-on-read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_reset_r <= 1'b0;
    end else begin
      in_reset_r <= rst_now || (in_reset_r && !rd_stat);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_nxt; // Read data for the addressed register

  // Read multiplexer; unmapped offsets and reserved bits read zero
  always_comb begin
    rd_nxt = 8'h00;
    case (reg_addr_i)
      DP_OFS_TURN: rd_nxt[2:0] = turn_code_r;
      DP_OFS_PORT_CONTROL_B: begin
        rd_nxt[DP_BIT_NACK_SUP] = nack_sup_r;
        rd_nxt[DP_BIT_CONT_OFF] = cont_off_r;
      end
      DP_OFS_KEY: begin
        rd_nxt[DP_BIT_KEY_UROW] = user_row_key_active_o;
        rd_nxt[DP_BIT_KEY_PROG] = memory_program_key_o;
        rd_nxt[DP_BIT_KEY_ERASE] = full_erase_key_o;
      end
      DP_OFS_SYSTEM_RESET_REQUEST: rd_nxt[0] = system_reset_request_o;
      DP_OFS_CLKSEL: rd_nxt[1:0] = clk_sel_r;
      DP_OFS_SYSCTL: rd_nxt[DP_BIT_CLK_REQ] = system_clock_request_o;
      DP_OFS_SYSSTAT: begin
        rd_nxt[DP_BIT_IN_RESET] = in_reset_r || rst_now;
        rd_nxt[DP_BIT_ASLEEP] = sys_s.asleep;
        rd_nxt[DP_BIT_PROG_RDY] = sys_s.prog_ready;
        rd_nxt[DP_BIT_ROW_RDY] = sys_s.row_ready;
        rd_nxt[DP_BIT_LOCKED] = sys_s.locked;
      end
      DP_OFS_CRC: begin
        // Only the documented one-hot codes pass; others read as off
        case (sys_s.crc)
          DP_CRC_BUSY, DP_CRC_GOOD, DP_CRC_FAIL: rd_nxt[2:0] = sys_s.crc;
          default: rd_nxt[2:0] = DP_CRC_OFF;
        endcase
      end
      default: rd_nxt = 8'h00;
    endcase
  end

  // Read data register, loaded on each read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end

endmodule : dp_ctrl_regs

// ==== sim/dp_dbg_model.sv ====
// Debugger adapter model that turns bench requests into register strobes
`timescale 1ns/10ps
module dp_dbg_model
  import dp_pkg::*;
(
  input wire logic clk_i,
  input wire logic [1:0] op_i, // 1 write, 2 read, 0 idle
  input wire logic [3:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [3:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  logic [7:0] last_r = 8'h00; // Last data written
  // Remember written data so an idle bus can show its inverse
  always_ff @(posedge clk_i) begin
    if (op_i == 2'h1) begin
      last_r <= data_i;
    end
  end
  assign reg_wr_o = (op_i == 2'h1);
  assign reg_rd_o = (op_i == 2'h2);
  assign reg_addr_o = addr_i;
  // Released data lines never repeat the last value, so stale data cannot pass
  assign reg_wdata_o = reg_wr_o ? data_i : ~last_r;
endmodule : dp_dbg_model

// ==== sim/dp_ctrl_regs_checker.sv ====
// Assertion checker for the debug port control registers
`timescale 1ns/10ps
module dp_ctrl_regs_checker
  import dp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic port_enable_i,
  input wire dp_phy_cfg_type phy_cfg_o,
  input wire logic phy_enable_o,
  input wire logic port_logic_reset_o,
  input wire logic nack_send_o,
  input wire logic system_reset_request_o,
  input wire logic system_clock_request_o,
  input wire logic user_row_done_o,
  input wire logic user_row_key_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr_rst; // Write to the reset request register
  logic wr_off; // Shutdown write
  assign wr_rst = reg_wr_i && reg_addr_i == DP_OFS_SYSTEM_RESET_REQUEST;
  assign wr_off = reg_wr_i && reg_addr_i == DP_OFS_PORT_CONTROL_B && reg_wdata_i[DP_BIT_SHUTDOWN];
  chk_rst_req_set: assert property (wr_rst && reg_wdata_i == DP_RST_SIGNATURE
    |=> system_reset_request_o) else $error("reset request not raised");
  chk_rst_req_clear: assert property (wr_rst && reg_wdata_i != DP_RST_SIGNATURE
    |=> !system_reset_request_o) else $error("reset request not released");
  chk_rst_req_read: assert property (reg_rd_i && reg_addr_i == DP_OFS_SYSTEM_RESET_REQUEST
    |=> reg_rdata_o == {7'h00, $past(system_reset_request_o)}) else $error("bad reset readback");
  chk_port_kept: assert property ($rose(system_reset_request_o)
    |-> $stable(phy_enable_o) && !port_logic_reset_o) else $error("port hit by system reset");
  chk_shutdown_all: assert property (wr_off |=> !phy_enable_o && port_logic_reset_o
    && !system_clock_request_o && !user_row_key_active_o && phy_cfg_o == 7'h03)
    else $error("shutdown incomplete");
  chk_nack_supp: assert property (phy_cfg_o.negative_ack_suppress
    && $past(phy_cfg_o.negative_ack_suppress) |-> !nack_send_o) else $error("nack not suppressed");
  chk_row_done: assert property (user_row_done_o == $past(reg_wr_i && reg_wdata_i[1]
    && reg_addr_i == DP_OFS_SYSCTL && user_row_key_active_o)) else $error("bad row done pulse");
  chk_clk_req_on: assert property (port_enable_i && !wr_off |=> system_clock_request_o
    && phy_cfg_o.port_clock_select == 2'h3) else $error("enable did not request clock");
endmodule : dp_ctrl_regs_checker
bind dp_ctrl_regs dp_ctrl_regs_checker u_chk (.*);

// ==== sim/dp_ctrl_regs_tb.sv ====
// Self-checking testbench of the debug port control registers
`timescale 1ns/10ps
module dp_ctrl_regs_tb;
  import dp_pkg::*;
  logic clk_i, rst_n_i, access_busy_i, contention_i, reg_wr_i, reg_rd_i;
  logic port_enable_i, key_row_i, key_prog_i, key_erase_i, turn_i;
  logic [4:0] stb; // Strobes: turn, erase, program, row, enable
  logic [1:0] op_kind; // Debugger request kind
  logic [3:0] reg_addr_i, op_addr;
  logic [7:0] reg_wdata_i, reg_rdata_o, op_data;
  dp_sys_type sys_i;
  dp_phy_cfg_type phy_cfg_o;
  logic phy_enable_o, port_logic_reset_o, bit_en_o, guard_busy_o, nack_send_o;
  logic contention_error_o, system_reset_request_o, system_clock_request_o;
  logic user_row_done_o, user_row_key_active_o, memory_program_key_o, full_erase_key_o;
  int err_count = 0;
  int n_tests = 0;
  assign {turn_i, key_erase_i, key_prog_i, key_row_i, port_enable_i} = stb;
  dp_ctrl_regs uut (.*);
  dp_dbg_model u_dbg (.clk_i(clk_i), .op_i(op_kind), .addr_i(op_addr), .data_i(op_data),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // A wait that ran out ends the run at once
  task automatic tmo(input int k);
    if (k >= 300) begin
      err_count++;
      print_verdict();
    end
  endtask : tmo
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // One bus cycle; results of the access are settled on return
  task automatic bus(input logic [1:0] k, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    op_kind <= k;
    op_addr <= a;
    op_data <= d;
    @(posedge clk_i);
    op_kind <= 2'h0;
    #1;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(2'h2, a, 8'h00);
    chk(reg_rdata_o, exp);
  endtask : rd
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_i);
    stb <= m;
    @(posedge clk_i);
    stb <= 5'h00;
    #1;
  endtask : pulse
  // Clock cycles between two bit enable pulses
  task automatic period(input int exp);
    int k;
    for (k = 0; bit_en_o !== 1'b1 && k < 300; k++) tick(1);
    tmo(k);
    tick(1);
    for (k = 1; bit_en_o !== 1'b1 && k < 300; k++) tick(1);
    tmo(k);
    chk(8'(k), 8'(exp));
  endtask : period
  task automatic t_reset_values();
    logic [3:0] a [9] = '{4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h5};
    logic [7:0] v [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rd(a[i], v[i]);
  endtask : t_reset_values
  task automatic t_enable_clock();
    pulse(5'h01);
    chk({6'h00, phy_enable_o, system_clock_request_o}, 8'h03);
    rd(DP_OFS_SYSCTL, 8'h01);
    period(DP_DIV_SLOW);
    bus(2'h1, DP_OFS_CLKSEL, 8'h01); // fast rate assumes top brown-out level
    period(DP_DIV_FAST);
    bus(2'h1, DP_OFS_CLKSEL, 8'h00);
    rd(DP_OFS_CLKSEL, 8'h01);
    bus(2'h1, DP_OFS_CLKSEL, 8'h02);
    period(DP_DIV_MID);
    bus(2'h1, DP_OFS_CLKSEL, 8'h01);
  endtask : t_enable_clock
  task automatic t_guard();
    int k;
    int n;
    n = 0;
    bus(2'h1, DP_OFS_TURN, 8'h06);
    pulse(5'h10);
    for (k = 0; guard_busy_o === 1'b1 && k < 300; k++) begin
      n += int'(bit_en_o);
      tick(1);
    end
    tmo(k);
    chk(8'(n), 8'h02);
    bus(2'h1, DP_OFS_TURN, 8'h07);
    pulse(5'h10);
    chk({7'h00, guard_busy_o}, 8'h00);
  endtask : t_guard
  // Reset during a load with contention on the line
  task automatic t_faults(input logic [7:0] cfg, input logic [7:0] exp);
    logic [7:0] seen;
    seen = 8'h00;
    bus(2'h1, DP_OFS_PORT_CONTROL_B, cfg);
    @(posedge clk_i);
    contention_i <= 1'b1;
    access_busy_i <= 1'b1;
    sys_i.reset_active <= 1'b1;
    repeat (8) begin
      tick(1);
      seen |= {6'h00, nack_send_o, contention_error_o};
    end
    chk(seen, exp);
    @(posedge clk_i);
    contention_i <= 1'b0;
    access_busy_i <= 1'b0;
    sys_i.reset_active <= 1'b0;
    tick(4);
  endtask : t_faults
  task automatic t_reset_req();
    rd(DP_OFS_SYSSTAT, 8'h21);
    rd(DP_OFS_SYSSTAT, 8'h01);
    bus(2'h1, DP_OFS_SYSTEM_RESET_REQUEST, 8'h59);
    rd(DP_OFS_SYSTEM_RESET_REQUEST, 8'h01);
    rd(DP_OFS_SYSSTAT, 8'h21);
    bus(2'h1, DP_OFS_SYSTEM_RESET_REQUEST, 8'h58);
    chk({7'h00, system_reset_request_o}, 8'h00);
    rd(DP_OFS_SYSSTAT, 8'h21);
    rd(DP_OFS_SYSSTAT, 8'h01);
  endtask : t_reset_req
  task automatic t_status();
    logic [2:0] c [5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h0};
    @(posedge clk_i);
    sys_i <= 10'h1c2;
    tick(4);
    rd(DP_OFS_SYSSTAT, 8'h1c);
    foreach (c[i]) begin
      @(posedge clk_i);
      sys_i.crc <= c[i];
      tick(4);
      rd(DP_OFS_CRC, {5'h00, (c[i] == 3'h3) ? 3'h0 : c[i]});
    end
  endtask : t_status
  task automatic t_keys();
    pulse(5'h02);
    rd(DP_OFS_KEY, 8'h20);
    bus(2'h1, DP_OFS_SYSCTL, 8'h03); // row data is taken as loaded
    chk({7'h00, user_row_done_o}, 8'h01);
    bus(2'h1, DP_OFS_KEY, 8'h00);
    bus(2'h1, DP_OFS_SYSCTL, 8'h03);
    chk({7'h00, user_row_done_o}, 8'h00);
    pulse(5'h0c);
    rd(DP_OFS_KEY, 8'h18);
    @(posedge clk_i);
    sys_i.prog_done <= 1'b1;
    tick(5);
    rd(DP_OFS_KEY, 8'h08);
    @(posedge clk_i);
    sys_i.erase_done <= 1'b1;
    tick(5);
    rd(DP_OFS_KEY, 8'h00);
  endtask : t_keys
  task automatic t_shutdown();
    pulse(5'h0e);
    bus(2'h1, DP_OFS_TURN, 8'h05);
    bus(2'h1, DP_OFS_CLKSEL, 8'h02);
    bus(2'h1, DP_OFS_SYSTEM_RESET_REQUEST, 8'h59);
    bus(2'h1, DP_OFS_PORT_CONTROL_B, 8'h04);
    chk({phy_enable_o, port_logic_reset_o, system_clock_request_o, system_reset_request_o,
      user_row_key_active_o, memory_program_key_o, full_erase_key_o, 1'b0}, 8'h40);
    chk({1'b0, phy_cfg_o}, 8'h03);
  endtask : t_shutdown
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    stb = 5'h00;
    op_kind = 2'h0;
    op_addr = 4'h0;
    op_data = 8'h00;
    access_busy_i = 1'b0;
    contention_i = 1'b0;
    sys_i = DP_SYS_RESET;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset_values();
    t_enable_clock();
    t_guard();
    t_faults(8'h18, 8'h00);
    t_faults(8'h00, 8'h03);
    t_reset_req();
    t_status();
    t_keys();
    t_shutdown();
    print_verdict();
  end
endmodule : dp_ctrl_regs_tb
